// ---- rtl/enc_regs_map.svh ----
// Register offsets, field positions, reset values and timing figures of the mode/timing bank
`ifndef ENC_REGS_MAP_SVH
`define ENC_REGS_MAP_SVH

// ==========================================================
// Register offsets (serial port subaddress)
`define OFS_OUTPUT_CONFIG 5'h04
`define OFS_TIMING_SELECT 5'h07
`define OFS_SYNC_ADJUST 5'h08

// ==========================================================
// Reset values
`define RST_OUTPUT_CONFIG 8'h00
`define RST_TIMING_SELECT 8'h00
`define RST_SYNC_ADJUST 8'h00
`define RDATA_UNMAPPED 8'h00

// ==========================================================
// output_config fields
`define B_OUTPUT_FORMAT 0
`define B_COMPONENT_FORMAT 1
`define B_COMPONENT_SYNC 2
`define B_LONG_VSYNC 3
`define B_PEDESTAL 4
`define B_BLANK_FILTER 5
`define B_SLEEP 6

// ==========================================================
// timing_select fields
`define B_MASTER_SLAVE 0
`define F_TIMING_MODE 2:1
`define B_BLANK_INPUT 3
`define F_LUMA_DELAY 5:4
`define B_COUNTER_RESET 7

// ==========================================================
// sync_adjust fields
`define F_LINE_SYNC_WIDTH 1:0
`define F_LINE_TO_FIELD 3:2
`define F_FIELD_EDGE_VSYNC 5:4
`define F_PIXEL_SHIFT 7:6

// ==========================================================
// Modes and timing figures
`define TIMING_MODE_1 2'h1
`define TIMING_MODE_2 2'h2
`define VSYNC_HALF_LINES_PAL 3'h5
`define VSYNC_HALF_LINES_NTSC 3'h6
`define VSYNC_HALF_LINES_NORMAL 3'h0
`define LUMA_STEP_PS 74000
`define MCLK_PERIOD_PS 5000

`endif

// ---- rtl/enc_regs_pkg.sv ----
// Types shared by the mode/timing register bank
package enc_regs_pkg;

	// ==========================================================
	// Decoded controls handed to the encoder datapath
	typedef struct packed {
		logic output_format_select;
		logic component_format_select;
		logic component_sync_enable;
		logic pedestal_enable;
		logic blanking_filter_enable;
		logic sleep_enable;
		logic master_slave_select;
		logic [1:0] timing_mode_field;
		logic blank_gate;
		logic [1:0] luma_delay_field;
		logic [1:0] line_sync_width;
		logic [1:0] line_to_field_offset;
		logic [1:0] field_edge_delay;
		logic [1:0] vsync_width;
		logic [1:0] line_sync_pixel_shift;
		logic [2:0] long_vertical_sync;
	} enc_ctrl_t;

	// ==========================================================
	// Counter-reset toggle tracker
	typedef enum logic [1:0] {
		TOG_ARMED = 2'b01,
		TOG_HIGH = 2'b10
	} tog_state_t;

endpackage

// ---- rtl/video_encoder_mode_timing_regs.sv ----
// Mode, output and sync timing registers of the video encoder, with luma delay line
`timescale 1ns/1ps
`include "enc_regs_map.svh"

module video_encoder_mode_timing_regs
	import enc_regs_pkg::*;
#(
	parameter int LUMA_W = 10
) (
	input wire logic mclk, // 200 MHz pixel-side clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [4:0] reg_addr, // Register subaddress
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
	output logic reg_rvalid, // Read data valid pulse
	input wire logic standard_is_pal, // Video standard: 1 PAL, 0 NTSC
	input wire logic blank_in_n, // External blanking input, active low
	input wire logic [LUMA_W-1:0] luma_in, // Luma samples in
	output logic [LUMA_W-1:0] luma_out, // Delayed luma samples out
	output enc_ctrl_t ctrl, // Decoded controls
	output logic timing_counter_clear // One-cycle counter clear pulse
);

	// ==========================================================
	// Timing figures
	localparam int LUMA_STEP_CYC = (`LUMA_STEP_PS + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS;
	localparam int LINE_DEPTH = 3 * LUMA_STEP_CYC;

	if (LUMA_W < 1 || LUMA_STEP_CYC < 1) begin : g_param_check
		$error("luma width and step must be at least one");
	end

	// ==========================================================
	// Register storage
	logic [7:0] output_config_r;
	logic [7:0] timing_select_r;
	logic [7:0] sync_adjust_r;
	logic [7:0] reg_rdata_nxt;

	// Decode stays live during sleep so the host can always wake the part
	wire sel_output_config = (reg_addr == `OFS_OUTPUT_CONFIG);
	wire sel_timing_select = (reg_addr == `OFS_TIMING_SELECT);
	wire sel_sync_adjust = (reg_addr == `OFS_SYNC_ADJUST);

	always_ff @(posedge mclk) begin
		if (srst) begin
			output_config_r <= `RST_OUTPUT_CONFIG;
			timing_select_r <= `RST_TIMING_SELECT;
			sync_adjust_r <= `RST_SYNC_ADJUST;
		end else if (reg_wr) begin
			if (sel_output_config) begin
				output_config_r <= reg_wdata;
			end
			if (sel_timing_select) begin
				timing_select_r <= reg_wdata;
			end
			if (sel_sync_adjust) begin
				sync_adjust_r <= reg_wdata;
			end
		end
	end

	assign reg_rdata_nxt = sel_output_config ? output_config_r :
		sel_timing_select ? timing_select_r :
		sel_sync_adjust ? sync_adjust_r : `RDATA_UNMAPPED;

	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= `RDATA_UNMAPPED;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= reg_rdata_nxt;
			end
		end
	end

	// ==========================================================
	// Control decode
	wire sleeping = output_config_r[`B_SLEEP];
	wire is_master = timing_select_r[`B_MASTER_SLAVE];
	wire [1:0] mode = timing_select_r[`F_TIMING_MODE];
	wire [1:0] shared_f = sync_adjust_r[`F_FIELD_EDGE_VSYNC];
	wire long_vs = output_config_r[`B_LONG_VSYNC];
	wire [2:0] vs_half = standard_is_pal ? `VSYNC_HALF_LINES_PAL : `VSYNC_HALF_LINES_NTSC;
	enc_ctrl_t ctrl_nxt;

	always_comb begin
		ctrl_nxt.output_format_select = output_config_r[`B_OUTPUT_FORMAT];
		ctrl_nxt.component_format_select = output_config_r[`B_COMPONENT_FORMAT];
		ctrl_nxt.component_sync_enable = output_config_r[`B_COMPONENT_SYNC];
		// PAL has no pedestal, so the bit is masked rather than trusted
		ctrl_nxt.pedestal_enable = output_config_r[`B_PEDESTAL] & ~standard_is_pal;
		ctrl_nxt.blanking_filter_enable = output_config_r[`B_BLANK_FILTER];
		ctrl_nxt.sleep_enable = sleeping;
		ctrl_nxt.master_slave_select = is_master;
		ctrl_nxt.timing_mode_field = mode;
		ctrl_nxt.blank_gate = ~is_master & timing_select_r[`B_BLANK_INPUT] & ~blank_in_n;
		ctrl_nxt.luma_delay_field = timing_select_r[`F_LUMA_DELAY];
		ctrl_nxt.line_sync_width = sync_adjust_r[`F_LINE_SYNC_WIDTH];
		ctrl_nxt.line_to_field_offset = sync_adjust_r[`F_LINE_TO_FIELD];
		ctrl_nxt.field_edge_delay = (mode == `TIMING_MODE_1) ? shared_f : 2'h0;
		ctrl_nxt.vsync_width = (mode == `TIMING_MODE_2) ? shared_f : 2'h0;
		ctrl_nxt.line_sync_pixel_shift = sync_adjust_r[`F_PIXEL_SHIFT];
		// Length in half lines; PAL or NTSC count picked by standard_is_pal
		ctrl_nxt.long_vertical_sync = long_vs ? vs_half : `VSYNC_HALF_LINES_NORMAL;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl <= '0;
		end else begin
			ctrl <= ctrl_nxt;
		end
	end

	// ==========================================================
	// Counter reset: clear fires on the falling half of low-high-low
	tog_state_t tog_r;
	tog_state_t tog_nxt;
	wire cnt_bit = timing_select_r[`B_COUNTER_RESET];
	logic clear_nxt;

	always_comb begin
		tog_nxt = tog_r;
		clear_nxt = 1'b0;
		case (tog_r)
			TOG_ARMED: begin
				if (cnt_bit) begin
					tog_nxt = TOG_HIGH;
				end
			end
			TOG_HIGH: begin
				if (!cnt_bit) begin
					tog_nxt = TOG_ARMED;
					clear_nxt = 1'b1;
				end
			end
			default: begin
				tog_nxt = TOG_ARMED;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tog_r <= TOG_ARMED;
			timing_counter_clear <= 1'b0;
		end else begin
			tog_r <= tog_nxt;
			timing_counter_clear <= clear_nxt;
		end
	end

	// ==========================================================
	// Luma delay line, 15 taps per step of the delay field
	logic [LUMA_W-1:0] dline [0:LINE_DEPTH-1];
	logic [LUMA_W-1:0] luma_nxt;

	always_ff @(posedge mclk) begin
		dline[0] <= luma_in;
	end

	genvar gi;
	generate
		for (gi = 1; gi < LINE_DEPTH; gi++) begin : g_dline
			always_ff @(posedge mclk) begin
				dline[gi] <= dline[gi-1];
			end
		end
	endgenerate

	wire [1:0] ldel = timing_select_r[`F_LUMA_DELAY];
	assign luma_nxt = (ldel == 2'h0) ? luma_in : dline[int'(ldel) * LUMA_STEP_CYC - 1];

	// Sleep parks luma_out at zero; the delay line keeps shifting
	always_ff @(posedge mclk) begin
		if (srst || sleeping) begin
			luma_out <= '0;
		end else begin
			luma_out <= luma_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// ==========================================================
	// Reset and wake by reset
	reset_zero_a: assert property ($fell(srst) |->
		ctrl == '0 && tog_r == TOG_ARMED && !timing_counter_clear
		&& !reg_rvalid && luma_out == '0)
		else $error("state not cleared by reset");

	reset_regs_a: assert property ($fell(srst) |->
		output_config_r == `RST_OUTPUT_CONFIG && timing_select_r == `RST_TIMING_SELECT
		&& sync_adjust_r == `RST_SYNC_ADJUST)
		else $error("registers not cleared by reset");

	// ==========================================================
	// Register port
	write_read_a: assert property (reg_wr && sel_timing_select ##1
		reg_rd && sel_timing_select && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
		else $error("readback mismatch");

	rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read valid missing");

	rvalid_idle_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without read");

	sleep_access_a: assert property (sleeping && reg_wr && sel_sync_adjust |=>
		sync_adjust_r == $past(reg_wdata))
		else $error("write lost in sleep");

	sleep_read_a: assert property (sleeping && reg_rd && sel_sync_adjust |=>
		reg_rvalid && reg_rdata == $past(sync_adjust_r))
		else $error("read lost in sleep");

	// ==========================================================
	// Control decode, two cycles from write to ctrl
	out_fields_a: assert property (reg_wr && sel_output_config |=> ##1
		ctrl.output_format_select == $past(reg_wdata[`B_OUTPUT_FORMAT], 2)
		&& ctrl.component_format_select == $past(reg_wdata[`B_COMPONENT_FORMAT], 2)
		&& ctrl.component_sync_enable == $past(reg_wdata[`B_COMPONENT_SYNC], 2)
		&& ctrl.blanking_filter_enable == $past(reg_wdata[`B_BLANK_FILTER], 2))
		else $error("output fields not applied");

	timing_fields_a: assert property (reg_wr && sel_timing_select |=> ##1
		ctrl.master_slave_select == $past(reg_wdata[`B_MASTER_SLAVE], 2)
		&& ctrl.timing_mode_field == $past(reg_wdata[`F_TIMING_MODE], 2)
		&& ctrl.luma_delay_field == $past(reg_wdata[`F_LUMA_DELAY], 2))
		else $error("timing fields not applied");

	sync_fields_a: assert property (reg_wr && sel_sync_adjust |=> ##1
		ctrl.line_sync_width == $past(reg_wdata[`F_LINE_SYNC_WIDTH], 2)
		&& ctrl.line_to_field_offset == $past(reg_wdata[`F_LINE_TO_FIELD], 2)
		&& ctrl.line_sync_pixel_shift == $past(reg_wdata[`F_PIXEL_SHIFT], 2))
		else $error("sync fields not applied");

	pedestal_pal_a: assert property (standard_is_pal |=> !ctrl.pedestal_enable)
		else $error("pedestal in pal");

	pedestal_ntsc_a: assert property (!standard_is_pal |=>
		ctrl.pedestal_enable == $past(output_config_r[`B_PEDESTAL]))
		else $error("pedestal lost in ntsc");

	long_vsync_a: assert property (long_vs && !standard_is_pal |=>
		ctrl.long_vertical_sync == `VSYNC_HALF_LINES_NTSC)
		else $error("vsync len");

	long_vsync_pal_a: assert property (long_vs && standard_is_pal |=>
		ctrl.long_vertical_sync == `VSYNC_HALF_LINES_PAL)
		else $error("pal vsync len");

	blank_master_a: assert property (is_master |=> !ctrl.blank_gate)
		else $error("blank in master");

	blank_slave_a: assert property (!is_master && timing_select_r[`B_BLANK_INPUT]
		&& !blank_in_n |=> ctrl.blank_gate)
		else $error("blank ignored in slave");

	shared_field_a: assert property (mode != `TIMING_MODE_2 |=>
		ctrl.vsync_width == 2'h0)
		else $error("vsync width outside mode 2");

	field_edge_a: assert property (mode != `TIMING_MODE_1 |=>
		ctrl.field_edge_delay == 2'h0)
		else $error("field edge delay outside mode 1");

	// ==========================================================
	// Sleep
	wake_write_a: assert property (sleeping && reg_wr && sel_output_config
		&& !reg_wdata[`B_SLEEP] |=> ##1 !ctrl.sleep_enable)
		else $error("no wake");

	sleep_luma_a: assert property (sleeping |=> luma_out == '0)
		else $error("luma active in sleep");

	// ==========================================================
	// Counter clear; a reset that drops the bit is not a toggle
	clear_seq_a: assert property ($fell(cnt_bit) && !$past(srst) |=>
		timing_counter_clear)
		else $error("missed counter clear");

	clear_cause_a: assert property (timing_counter_clear |->
		$past(cnt_bit, 2) && !$past(cnt_bit))
		else $error("spurious counter clear");

	clear_once_a: assert property (timing_counter_clear |=> !timing_counter_clear)
		else $error("counter clear too long");

	// ==========================================================
	// Luma delay
	luma_step_a: assert property ((ldel == 2'h1 && !sleeping) [*8] ##0
		(ldel == 2'h1 && !sleeping) [*8] |=> luma_out == $past(luma_in, LUMA_STEP_CYC + 1))
		else $error("luma delay step");

	luma_pass_a: assert property (ldel == 2'h0 && !sleeping |=>
		luma_out == $past(luma_in))
		else $error("luma not passed through");

	sleep_cover_c: cover property (sleeping ##1 !sleeping);
	clear_cover_c: cover property (timing_counter_clear);
	delay_cover_c: cover property (ldel == 2'h3 && !sleeping);
	mode2_cover_c: cover property (mode == `TIMING_MODE_2 && shared_f != 2'h0);
	readback_cover_c: cover property (reg_wr ##1 reg_rd ##1 reg_rvalid);

endmodule // video_encoder_mode_timing_regs

// ---- test/video_source_model.sv ----
// Pixel-side source model: luma ramp and blanking strobe
`timescale 1ns/1ps
module video_source_model #(
	parameter int LUMA_W = 10
) (
	input wire logic mclk, // Pixel clock
	input wire logic blank_req, // Bench asks for blanking
	output logic [LUMA_W-1:0] luma_in, // Ramp, one step a cycle
	output logic blank_in_n // Blanking, active low
);
	logic [LUMA_W-1:0] ramp_r = '0;
	// A ramp makes each sample unique, so a wrong delay never matches
	always @(negedge mclk) ramp_r <= ramp_r + 1'b1;
	assign luma_in = ramp_r;
	assign blank_in_n = ~blank_req;
endmodule // video_source_model

// ---- test/test_video_encoder_mode_timing_regs.sv ----
// Self-checking bench for the mode/timing register bank
`timescale 1ns/1ps
`include "enc_regs_map.svh"
module test_video_encoder_mode_timing_regs
	import enc_regs_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic standard_is_pal = 1'b0;
	logic blank_req = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid, blank_in_n, timing_counter_clear;
	logic [9:0] luma_in, luma_out;
	enc_ctrl_t ctrl;
	int miscompares = 0;
	int checks = 0;

	always #2.5 mclk = ~mclk;

	video_source_model #(.LUMA_W(10)) src (.mclk(mclk), .blank_req(blank_req),
		.luma_in(luma_in), .blank_in_n(blank_in_n));
	video_encoder_mode_timing_regs #(.LUMA_W(10)) dut (.mclk(mclk), .srst(srst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .standard_is_pal(standard_is_pal),
		.blank_in_n(blank_in_n), .luma_in(luma_in), .luma_out(luma_out), .ctrl(ctrl),
		.timing_counter_clear(timing_counter_clear));

	// ==========================================================
	// Access and compare tasks
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 1'b0;
		cmp("reg_rvalid", 16'h1, {15'h0, reg_rvalid});
		cmp("reg_rdata", {8'h0, e}, {8'h0, reg_rdata});
	endtask

	// Read on the cycle right after the write
	task automatic wr_rd(input logic [4:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		cmp("reg_rvalid", 16'h1, {15'h0, reg_rvalid});
		cmp("reg_rdata", {8'h0, d}, {8'h0, reg_rdata});
		@(negedge mclk);
		cmp("reg_rvalid", 16'h0, {15'h0, reg_rvalid});
	endtask

	// Waits past the 45-deep line so every tap is filled
	task automatic luma_chk(input int d);
		cyc(60);
		#1;
		cmp("luma_out", {6'h0, 10'(luma_in - 10'(d))}, {6'h0, luma_out});
	endtask

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_sim();
	end

	// ==========================================================
	// Main sequence
	initial begin
		cyc(2);
		srst = 1'b0;
		rd(`OFS_OUTPUT_CONFIG, `RST_OUTPUT_CONFIG);
		rd(`OFS_TIMING_SELECT, `RST_TIMING_SELECT);
		rd(`OFS_SYNC_ADJUST, `RST_SYNC_ADJUST);
		wr(5'h05, 8'hff);
		rd(5'h05, `RDATA_UNMAPPED);
		// Reserved top bit kept zero
		wr(`OFS_OUTPUT_CONFIG, 8'h3f);
		cyc(1);
		cmp("out_fmt", 16'h1, 16'(ctrl.output_format_select));
		cmp("comp_fmt", 16'h1, 16'(ctrl.component_format_select));
		cmp("comp_sync", 16'h1, 16'(ctrl.component_sync_enable));
		cmp("pedestal", 16'h1, 16'(ctrl.pedestal_enable));
		cmp("blank_filt", 16'h1, 16'(ctrl.blanking_filter_enable));
		cmp("long_vs", 16'h6, 16'(ctrl.long_vertical_sync));
		standard_is_pal = 1'b1;
		cyc(2);
		cmp("pedestal", 16'h0, 16'(ctrl.pedestal_enable));
		cmp("long_vs", 16'h5, 16'(ctrl.long_vertical_sync));
		rd(`OFS_OUTPUT_CONFIG, 8'h3f);
		blank_req = 1'b1;
		// Master/slave bit kept zero (slave)
		wr(`OFS_TIMING_SELECT, 8'h3a);
		wr(`OFS_SYNC_ADJUST, 8'h9e);
		cyc(1);
		cmp("master", 16'h0, 16'(ctrl.master_slave_select));
		cmp("mode", 16'h1, 16'(ctrl.timing_mode_field));
		cmp("blank_gate", 16'h1, 16'(ctrl.blank_gate));
		cmp("hs_width", 16'h2, 16'(ctrl.line_sync_width));
		cmp("hs_field", 16'h3, 16'(ctrl.line_to_field_offset));
		cmp("edge_dly", 16'h1, 16'(ctrl.field_edge_delay));
		cmp("vs_width", 16'h0, 16'(ctrl.vsync_width));
		cmp("pix_shift", 16'h2, 16'(ctrl.line_sync_pixel_shift));
		luma_chk(46);
		wr_rd(`OFS_TIMING_SELECT, 8'h3d);
		cyc(1);
		cmp("master", 16'h1, 16'(ctrl.master_slave_select));
		cmp("mode", 16'h2, 16'(ctrl.timing_mode_field));
		cmp("blank_gate", 16'h0, 16'(ctrl.blank_gate));
		cmp("edge_dly", 16'h0, 16'(ctrl.field_edge_delay));
		cmp("vs_width", 16'h1, 16'(ctrl.vsync_width));
		cmp("long_vs", 16'h5, 16'(ctrl.long_vertical_sync));
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_TIMING_SELECT, {2'b00, 2'(i), 4'h0});
			luma_chk(1 + 15 * i);
			cmp("luma_field", 16'(i), 16'(ctrl.luma_delay_field));
		end
		// Counter clear needs the full low-high-low sequence
		wr(`OFS_TIMING_SELECT, 8'h80);
		cyc(2);
		cmp("clear", 16'h0, 16'(timing_counter_clear));
		wr(`OFS_TIMING_SELECT, 8'h00);
		cmp("clear", 16'h0, 16'(timing_counter_clear));
		cyc(1);
		cmp("clear", 16'h1, 16'(timing_counter_clear));
		cyc(1);
		cmp("clear", 16'h0, 16'(timing_counter_clear));
		wr(`OFS_OUTPUT_CONFIG, 8'h40);
		cyc(2);
		cmp("luma_out", 16'h0, {6'h0, luma_out});
		cmp("sleep", 16'h1, 16'(ctrl.sleep_enable));
		wr(`OFS_SYNC_ADJUST, 8'h5a);
		rd(`OFS_SYNC_ADJUST, 8'h5a);
		wr(`OFS_OUTPUT_CONFIG, 8'h00);
		luma_chk(1);
		cmp("sleep", 16'h0, 16'(ctrl.sleep_enable));
		wr(`OFS_OUTPUT_CONFIG, 8'h40);
		cyc(1);
		cmp("sleep", 16'h1, 16'(ctrl.sleep_enable));
		srst = 1'b1;
		cyc(2);
		srst = 1'b0;
		rd(`OFS_OUTPUT_CONFIG, 8'h00);
		rd(`OFS_SYNC_ADJUST, 8'h00);
		luma_chk(1);
		cmp("sleep", 16'h0, 16'(ctrl.sleep_enable));
		end_sim();
	end
endmodule // test_video_encoder_mode_timing_regs
